// ===== core/pts_consts.svh
/*
 * Register offsets, field positions, reset values and timing figures of the
 * port, trigger and list sequencer block.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef PTS_CONSTS_SVH
`define PTS_CONSTS_SVH

// Register byte offsets.
`define PTS_A_CTRL 8'h00
`define PTS_A_CMD 8'h04
`define PTS_A_COUNT 8'h08
`define PTS_A_NSTEPS 8'h0C
`define PTS_A_SADDR 8'h10
`define PTS_A_SVOLT 8'h14
`define PTS_A_SCURR 8'h18
`define PTS_A_SWID 8'h1C
`define PTS_A_LOCK 8'h20
`define PTS_A_UNLOCK 8'h24
`define PTS_A_STATUS 8'h28

// Control register field positions and width.
`define PTS_CTRL_W 17
`define PTS_F_SRC 0
`define PTS_F_FUNC 2
`define PTS_F_SHUT 4
`define PTS_F_FSRC 6
`define PTS_F_LMODE 9
`define PTS_F_LAYOUT 10
`define PTS_F_REMOTE 12
`define PTS_F_DIO 13
`define PTS_F_SLOT 14

// Command register bits.
`define PTS_C_TRG 0
`define PTS_C_ON 1
`define PTS_C_OFF 2

// Reset values.
`define PTS_CTRL_RST 17'h00000
`define PTS_COUNT_RST 16'h0001
`define PTS_NSTEPS_RST 8'h00

// Timing: clock period, the list time unit and the minimum trigger pulse width, in ns.
`define PTS_CLK_NS 100
`define PTS_MS_NS 1000000
`define PTS_TRIG_MIN_NS 5000000

`endif

// ===== core/pts_pkg.sv
/*
 * Types of the port, trigger and list sequencer block.
 * Assumes pts_consts.svh holds the numeric constants.
 */
package pts_pkg;
    typedef enum logic [1:0] {pts_src_key = 2'h0, pts_src_ext = 2'h1, pts_src_bus = 2'h2} pts_src_t;
    typedef enum logic [1:0] {pts_fn_trig = 2'h0, pts_fn_sf = 2'h1, pts_fn_dio = 2'h2} pts_func_t;
    typedef enum logic [1:0] {pts_sh_off = 2'h0, pts_sh_latch = 2'h1, pts_sh_live = 2'h2} pts_shut_t;
    typedef enum logic [2:0] {
        pts_fs_off = 3'h0, pts_fs_questionable_summary_bit = 3'h1, pts_fs_operation_summary_bit = 3'h2, pts_fs_esb = 3'h3,
        pts_fs_rqs = 3'h4
    } pts_fsrc_t;
    typedef enum logic [3:0] {
        pts_st_idle = 4'h1, pts_st_armed = 4'h2, pts_st_run = 4'h4, pts_st_hold = 4'h8
    } pts_state_t;
endpackage

// ===== core/pts_list_store.sv
/*
 * Flip-flop storage of list steps: all slots, each of up to STEPS entries.
 * Assumes the caller keeps indices below DEPTH; read is combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module pts_list_store #(
    parameter int DEPTH = 1600,
    parameter int W = 48,
    parameter int IW = 11
) (
    // Clock
    input wire logic core_clk,
    // Write side
    input wire logic wr_en,
    input wire logic [IW-1:0] wr_idx,
    input wire logic [W-1:0] wr_data,
    // Read side
    input wire logic [IW-1:0] rd_idx,
    output logic [W-1:0] rd_data
);
    // Step data carries no reset; only control state needs a defined value.
    logic [W-1:0] mem_r [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem_r[rd_idx];
endmodule
`default_nettype wire

// ===== core/pts_top.sv
/*
 * Rear port, trigger source, shutoff, fault output, key lock, output on/off
 * and list sequencer of a programmable supply.
 * Assumes key and command strobes are one-cycle pulses synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pts_consts.svh"
module pts_top #(
    parameter int STEPS = 200,
    parameter int SLOTS = 8,
    parameter int MS_CYCLES = `PTS_MS_NS / `PTS_CLK_NS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Front panel keys
    input wire logic key_trigger,
    input wire logic key_list,
    input wire logic key_onoff,
    // Status summary bits
    input wire logic questionable_summary_bit,
    input wire logic operation_summary_bit,
    input wire logic event_summary_bit,
    input wire logic service_request_bit,
    // Rear port
    input wire logic shutoff_pin,
    output logic fault_pin_o,
    output logic fault_pin_oe_b,
    // Output and list
    output logic output_enable,
    output logic trig_event,
    output var pts_pkg::pts_state_t list_state,
    output logic [15:0] volt_set,
    output logic [15:0] curr_set
);
    import pts_pkg::*;

    localparam int IW = $clog2(SLOTS * STEPS);
    localparam int PW = $clog2(MS_CYCLES);

    function automatic logic edge_det(input logic was, input logic now);
        return was & ~now;
    endfunction

    function automatic logic [IW-1:0] mem_idx(input logic [2:0] slot, input logic [7:0] step);
        return IW'(int'(slot) * STEPS + int'(step));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic rst_m_r, rst_sync_b;
    logic pin_m_r, pin_s_r, pin_d_r;
    logic [`PTS_CTRL_W-1:0] ctrl_r;
    logic [15:0] count_r, svolt_r, scurr_r, pass_r, cyc_r, elap_r;
    logic [7:0] nsteps_r, sstep_r, step_r;
    logic [2:0] sslot_r;
    logic [PW-1:0] pre_r;
    logic out_state_r, out_nxt, live_block, locked, list_key, trig_nxt;
    logic bus_trg, cmd_on, cmd_off, pin_rise, pin_fall, slot_ok, commit;
    logic tick, step_done, last, all_done, busy;
    logic [15:0] wid_eff;
    logic [47:0] rd_data;
    pts_state_t state_nxt;
    pts_src_t src;
    pts_func_t func;
    pts_shut_t shut;
    pts_fsrc_t fsrc;

    assign src = pts_src_t'(ctrl_r[`PTS_F_SRC +: 2]);
    assign func = pts_func_t'(ctrl_r[`PTS_F_FUNC +: 2]);
    assign shut = pts_shut_t'(ctrl_r[`PTS_F_SHUT +: 2]);
    assign fsrc = pts_fsrc_t'(ctrl_r[`PTS_F_FSRC +: 3]);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_r <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_sync_b <= rst_m_r;
        end
    end

    // Idle level of the pin is high, so no false fall appears after reset.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pin_m_r <= 1'b1;
            pin_s_r <= 1'b1;
            pin_d_r <= 1'b1;
        end else begin
            pin_m_r <= shutoff_pin;
            pin_s_r <= pin_m_r;
            pin_d_r <= pin_s_r;
        end
    end
    assign pin_rise = edge_det(pin_s_r, pin_d_r);
    assign pin_fall = edge_det(pin_d_r, pin_s_r);

    ////////////////////////////////////////////////////////////////////////////
    // Register writes.
    assign bus_trg = reg_wr && reg_addr == `PTS_A_CMD && reg_wdata[`PTS_C_TRG];
    assign cmd_on = reg_wr && reg_addr == `PTS_A_CMD && reg_wdata[`PTS_C_ON];
    assign cmd_off = reg_wr && reg_addr == `PTS_A_CMD && reg_wdata[`PTS_C_OFF];
    // A slot beyond the group count of the current layout is refused.
    assign slot_ok = {1'b0, sslot_r} < (4'h1 << ctrl_r[`PTS_F_LAYOUT +: 2]);
    assign commit = reg_wr && reg_addr == `PTS_A_SWID && slot_ok && int'(sstep_r) < STEPS;
    assign locked = pass_r != 16'h0000;

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ctrl_r <= `PTS_CTRL_RST;
            count_r <= `PTS_COUNT_RST;
            nsteps_r <= `PTS_NSTEPS_RST;
            svolt_r <= 16'h0000;
            scurr_r <= 16'h0000;
        end else if (reg_wr) begin
            case (reg_addr)
                `PTS_A_CTRL: ctrl_r <= reg_wdata[`PTS_CTRL_W-1:0];
                `PTS_A_COUNT: count_r <= reg_wdata[15:0];
                `PTS_A_NSTEPS: begin
                    nsteps_r <= (int'(reg_wdata[7:0]) > STEPS) ? 8'(STEPS) : reg_wdata[7:0];
                end
                `PTS_A_SVOLT: svolt_r <= reg_wdata[15:0];
                `PTS_A_SCURR: scurr_r <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // The step pointer advances on each accepted width write so a list loads in a burst.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sslot_r <= 3'h0;
            sstep_r <= 8'h00;
        end else if (reg_wr && reg_addr == `PTS_A_SADDR) begin
            sslot_r <= reg_wdata[10:8];
            sstep_r <= reg_wdata[7:0];
        end else if (commit) begin
            sstep_r <= sstep_r + 8'h01;
        end
    end

    // A zero password means unlocked; the password itself never reads back.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pass_r <= 16'h0000;
        end else if (reg_wr && reg_addr == `PTS_A_LOCK && !locked) begin
            pass_r <= reg_wdata[15:0];
        end else if (reg_wr && reg_addr == `PTS_A_UNLOCK && reg_wdata[15:0] == pass_r) begin
            pass_r <= 16'h0000;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `PTS_A_CTRL: reg_rdata <= {15'h0000, ctrl_r};
                `PTS_A_COUNT: reg_rdata <= {16'h0000, count_r};
                `PTS_A_NSTEPS: reg_rdata <= {24'h000000, nsteps_r};
                `PTS_A_SADDR: reg_rdata <= {21'h000000, sslot_r, sstep_r};
                `PTS_A_SVOLT: reg_rdata <= {16'h0000, svolt_r};
                `PTS_A_SCURR: reg_rdata <= {16'h0000, scurr_r};
                `PTS_A_STATUS: begin
                    reg_rdata <= {cyc_r, step_r, list_state, busy,
                        ctrl_r[`PTS_F_REMOTE] && func == pts_fn_dio && pin_s_r,
                        locked, output_enable};
                end
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output on/off. Shutoff beats a key press in the same cycle, for safety.
    always_comb begin
        out_nxt = out_state_r;
        if (func == pts_fn_sf && shut == pts_sh_latch && pin_fall) begin
            out_nxt = 1'b0;
        end else if (key_onoff) begin
            out_nxt = ~out_state_r;
        end else if (ctrl_r[`PTS_F_REMOTE] && cmd_on) begin
            out_nxt = 1'b1;
        end else if (ctrl_r[`PTS_F_REMOTE] && cmd_off) begin
            out_nxt = 1'b0;
        end
    end
    // Only the live and latching modes look at the pin; off leaves it unread.
    assign live_block = func == pts_fn_sf && shut == pts_sh_live && !pin_s_r;

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            out_state_r <= 1'b0;
            output_enable <= 1'b0;
        end else begin
            out_state_r <= out_nxt;
            output_enable <= out_nxt & ~live_block;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger selection; the lock gates the trigger and list keys only.
    assign list_key = key_list && !locked;
    assign trig_nxt = (src == pts_src_key && key_trigger && !locked) ||
        (src == pts_src_ext && func == pts_fn_trig && pin_rise) ||
        (src == pts_src_bus && bus_trg);

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            trig_event <= 1'b0;
        end else begin
            trig_event <= trig_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // List sequencer.
    pts_list_store #(
        .DEPTH(SLOTS * STEPS),
        .W(48),
        .IW(IW)
    ) u_store (
        .core_clk(core_clk),
        .wr_en(commit),
        .wr_idx(mem_idx(sslot_r, sstep_r)),
        .wr_data({svolt_r, scurr_r, reg_wdata[15:0]}),
        .rd_idx(mem_idx(ctrl_r[`PTS_F_SLOT +: 3], step_r)),
        .rd_data(rd_data)
    );

    assign busy = list_state != pts_st_idle;
    assign wid_eff = (rd_data[15:0] == 16'h0000) ? 16'h0001 : rd_data[15:0];
    assign tick = pre_r == PW'(MS_CYCLES - 1);
    assign step_done = tick && ({1'b0, elap_r} + 17'h00001 >= {1'b0, wid_eff});
    assign last = step_r == nsteps_r - 8'h01;
    assign all_done = last && cyc_r <= 16'h0001;

    always_comb begin
        state_nxt = list_state;
        case (list_state)
            pts_st_idle: begin
                if (list_key) state_nxt = pts_st_armed;
            end
            pts_st_armed: begin
                if (list_key) begin
                    state_nxt = pts_st_idle;
                end else if (trig_nxt && nsteps_r != 8'h00) begin
                    state_nxt = ctrl_r[`PTS_F_LMODE] ? pts_st_hold : pts_st_run;
                end
            end
            pts_st_run: begin
                if (list_key) state_nxt = pts_st_idle;
                else if (step_done && all_done) state_nxt = pts_st_armed;
            end
            pts_st_hold: begin
                if (list_key) state_nxt = pts_st_idle;
                else if (trig_nxt && all_done) state_nxt = pts_st_armed;
            end
            default: state_nxt = pts_st_idle;
        endcase
    end

    // Triggers in idle or during a timed pass are not looked at here, so they drop.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            list_state <= pts_st_idle;
            step_r <= 8'h00;
            cyc_r <= 16'h0000;
        end else begin
            list_state <= state_nxt;
            if (list_state == pts_st_armed || list_state == pts_st_idle) begin
                step_r <= 8'h00;
                cyc_r <= (count_r == 16'h0000) ? 16'h0001 : count_r;
            end else if ((list_state == pts_st_run && step_done) ||
                (list_state == pts_st_hold && trig_nxt)) begin
                step_r <= last ? 8'h00 : step_r + 8'h01;
                cyc_r <= last ? cyc_r - 16'h0001 : cyc_r;
            end
        end
    end

    // The millisecond prescaler only runs in a timed pass; step mode ignores widths.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pre_r <= '0;
            elap_r <= 16'h0000;
        end else if (list_state != pts_st_run || step_done) begin
            pre_r <= '0;
            elap_r <= 16'h0000;
        end else if (tick) begin
            pre_r <= '0;
            elap_r <= elap_r + 16'h0001;
        end else begin
            pre_r <= pre_r + PW'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            volt_set <= 16'h0000;
            curr_set <= 16'h0000;
        end else if (list_state == pts_st_run || list_state == pts_st_hold) begin
            volt_set <= rd_data[47:32];
            curr_set <= rd_data[31:16];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault pin. In trigger function the pin is released, since it serves as the trigger input.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            fault_pin_o <= 1'b1;
            fault_pin_oe_b <= 1'b1;
        end else begin
            case (func)
                pts_fn_sf: begin
                    fault_pin_oe_b <= 1'b0;
                    case (fsrc)
                        pts_fs_questionable_summary_bit: fault_pin_o <= ~questionable_summary_bit;
                        pts_fs_operation_summary_bit: fault_pin_o <= operation_summary_bit;
                        pts_fs_esb: fault_pin_o <= event_summary_bit;
                        pts_fs_rqs: fault_pin_o <= service_request_bit;
                        default: fault_pin_o <= 1'b1;
                    endcase
                end
                pts_fn_dio: begin
                    fault_pin_oe_b <= 1'b0;
                    fault_pin_o <= ctrl_r[`PTS_F_DIO];
                end
                default: begin
                    fault_pin_oe_b <= 1'b1;
                    fault_pin_o <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_b);

    a_fault_off_high: assert property ((func == pts_fn_sf && fsrc == pts_fs_off)
        |=> fault_pin_o && !fault_pin_oe_b) else $error("fault pin not high with source off");
    a_fault_questionable_summary_bit_inv: assert property ((func == pts_fn_sf && fsrc == pts_fs_questionable_summary_bit)
        |=> fault_pin_o == !$past(questionable_summary_bit)) else $error("fault pin not inverted");
    a_fault_operation_summary_bit_bit: assert property ((func == pts_fn_sf && fsrc == pts_fs_operation_summary_bit)
        |=> fault_pin_o == $past(operation_summary_bit)) else $error("fault pin not following");
    a_trig_pin_float: assert property (func == pts_fn_trig |=> fault_pin_oe_b)
        else $error("fault pin driven in trigger function");
    a_dio_out_drive: assert property (func == pts_fn_dio
        |=> !fault_pin_oe_b && fault_pin_o == $past(ctrl_r[`PTS_F_DIO]))
        else $error("digital output wrong");
    a_latch_turn_off: assert property ((func == pts_fn_sf && shut == pts_sh_latch && pin_fall)
        |=> !output_enable) else $error("latching shutoff missed");
    a_live_pin_low: assert property (live_block |=> !output_enable)
        else $error("live shutoff missed");
    a_onoff_toggles: assert property ((key_onoff && !live_block && !pin_fall
        && output_enable == out_state_r) |=> output_enable != $past(output_enable))
        else $error("on/off key did not toggle");
    a_lock_keeps_idle: assert property ((locked && list_state == pts_st_idle)
        |=> list_state == pts_st_idle) else $error("locked key armed list");
    a_run_drops_trig: assert property ((list_state == pts_st_run && trig_nxt
        && !step_done && !list_key) |=> $stable(step_r) && list_state == pts_st_run)
        else $error("trigger acted during pass");
    a_hold_waits: assert property ((list_state == pts_st_hold && !trig_nxt && !list_key)
        |=> $stable(step_r) && list_state == pts_st_hold) else $error("step advanced alone");
    a_arm_starts: assert property ((list_state == pts_st_armed && trig_nxt && !list_key
        && nsteps_r != 8'h00) |=> list_state == pts_st_run || list_state == pts_st_hold)
        else $error("armed list did not start");

    c_cont_pass: cover property (list_state == pts_st_run ##[1:1000] list_state == pts_st_armed);
    c_step_adv: cover property (list_state == pts_st_hold && trig_nxt && !all_done);
    c_latch_off: cover property (output_enable ##1 pin_fall ##1 !output_enable);
    c_locked: cover property ($rose(locked));
endmodule
`default_nettype wire

// ===== tb/pts_ttl_src.sv
/* Model of the external TTL equipment that drives the rear port pin.
 * Assumes the bench calls its tasks from the core_clk domain. */
`timescale 1ns/1ps
`default_nettype none
`include "pts_consts.svh"
module pts_ttl_src #(
    parameter int MIN_HI = `PTS_TRIG_MIN_NS / `PTS_CLK_NS
) (
    // Clock
    input wire logic core_clk,
    // Rear pin
    output logic pin
);
    // The pin idles high, as TTL equipment holds it between events.
    initial begin
        pin = 1'b1;
    end
    task automatic set_lvl(input logic v);
        @(posedge core_clk);
        pin <= v;
    endtask
    // A trigger pulse is never shorter than the minimum width the port needs.
    task automatic pulse();
        set_lvl(1'b0);
        set_lvl(1'b1);
        repeat (MIN_HI) @(posedge core_clk);
        pin <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
/* Self-checking bench of the port, trigger, shutoff and list block.
 * Assumes the TTL source model drives the rear pin. */
`timescale 1ns/1ps
`default_nettype none
`include "pts_consts.svh"
module tb_top;
    import pts_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] a;
    logic [31:0] wd, rdt;
    logic wr, rd, kt, kl, ko;
    logic [3:0] sb;
    logic [3:0] m;
    logic pin, fo, foe, oen, te;
    pts_state_t ls;
    logic [15:0] vs, cs;
    int err_total = 0, samples_checked = 0;
    pts_top #(.MS_CYCLES(4)) u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(a),
        .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdt), .key_trigger(kt),
        .key_list(kl), .key_onoff(ko), .questionable_summary_bit(sb[0]),
        .operation_summary_bit(sb[1]), .event_summary_bit(sb[2]), .service_request_bit(sb[3]),
        .shutoff_pin(pin), .fault_pin_o(fo), .fault_pin_oe_b(foe), .output_enable(oen),
        .trig_event(te), .list_state(ls), .volt_set(vs), .curr_set(cs));
    pts_ttl_src u_ttl (.core_clk(core_clk), .pin(pin));
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wrr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        a <= ad;
        wd <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [31:0] mk, input logic [31:0] e);
        @(posedge core_clk);
        a <= ad;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 ck(rdt & mk, e);
    endtask
    // Key 0 is trigger, 1 is list, 2 is on/off.
    task automatic press(input int k);
        @(posedge core_clk);
        kt <= (k == 0);
        kl <= (k == 1);
        ko <= (k == 2);
        @(posedge core_clk);
        kt <= 1'b0;
        kl <= 1'b0;
        ko <= 1'b0;
    endtask
    // Looks a few cycles for a trigger pulse, since the exact lag depends on the source.
    task automatic tev(input logic e);
        logic f;
        f = 1'b0;
        repeat (6) begin
            #1 f = f | (te === 1'b1);
            @(posedge core_clk);
        end
        ck(32'(f), 32'(e));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdc(`PTS_A_CTRL, 32'hFFFFFFFF, 32'h0);
        rdc(`PTS_A_COUNT, 32'hFFFFFFFF, 32'h1);
        rdc(`PTS_A_STATUS, 32'h2, 32'h0);
        rdc(8'h3C, 32'hFFFFFFFF, 32'h0);
        ck({fo, foe, oen}, 32'h6);
    endtask
    task automatic t_out();
        press(2);
        cyc(1);
        ck(oen, 1);
        wrr(`PTS_A_CTRL, 32'h1000);
        wrr(`PTS_A_CMD, 32'h4);
        cyc(2);
        ck(oen, 0);
        wrr(`PTS_A_CMD, 32'h2);
        cyc(2);
        ck(oen, 1);
    endtask
    task automatic t_shut();
        wrr(`PTS_A_CTRL, 32'h14);
        u_ttl.set_lvl(1'b0);
        cyc(6);
        ck(oen, 0);
        u_ttl.set_lvl(1'b1);
        cyc(6);
        ck(oen, 0);
        wrr(`PTS_A_CTRL, 32'h24);
        press(2);
        cyc(6);
        ck(oen, 1);
        u_ttl.set_lvl(1'b0);
        cyc(6);
        ck(oen, 0);
        wrr(`PTS_A_CTRL, 32'h04);
        cyc(6);
        ck(oen, 1);
        u_ttl.set_lvl(1'b1);
        press(2);
    endtask
    task automatic t_fault();
        for (int k = 0; k < 5; k++) begin
            for (int v = 0; v < 2; v++) begin
                m = (k == 0) ? 4'h0 : 4'h1 << (k - 1);
                wrr(`PTS_A_CTRL, 32'h4 | (k << 6));
                sb <= (v == 1) ? m : ~m;
                cyc(3);
                ck({fo, foe}, (k == 0 || (k == 1) != (v == 1)) ? 2 : 0);
            end
        end
        wrr(`PTS_A_CTRL, 32'h0);
        cyc(2);
        ck({fo, foe}, 32'h3);
    endtask
    task automatic t_dio();
        wrr(`PTS_A_CTRL, 32'h3008);
        cyc(2);
        ck({fo, foe}, 32'h2);
        rdc(`PTS_A_STATUS, 32'h4, 32'h4);
        wrr(`PTS_A_CTRL, 32'h1008);
        u_ttl.set_lvl(1'b0);
        cyc(6);
        ck(fo, 0);
        rdc(`PTS_A_STATUS, 32'h4, 32'h0);
        u_ttl.set_lvl(1'b1);
        wrr(`PTS_A_CTRL, 32'h0008);
        cyc(6);
        rdc(`PTS_A_STATUS, 32'h4, 32'h0);
    endtask
    task automatic t_lock();
        wrr(`PTS_A_LOCK, 32'h1234);
        rdc(`PTS_A_STATUS, 32'h2, 32'h2);
        press(1);
        cyc(2);
        ck(32'(ls), 32'h1);
        press(2);
        cyc(1);
        ck(oen, 1);
        wrr(`PTS_A_UNLOCK, 32'h1234);
        rdc(`PTS_A_STATUS, 32'h2, 32'h0);
    endtask
    task automatic t_list();
        // With one group only slot 0 exists, so this width write must not move the pointer.
        wrr(`PTS_A_SADDR, 32'h100);
        wrr(`PTS_A_SWID, 32'h1);
        rdc(`PTS_A_SADDR, 32'hFFFFFFFF, 32'h100);
        wrr(`PTS_A_SADDR, 32'h0);
        for (int i = 0; i < 2; i++) begin
            wrr(`PTS_A_SVOLT, 32'hA00 + i);
            wrr(`PTS_A_SCURR, 32'h500 + i);
            wrr(`PTS_A_SWID, 32'h1);
        end
        wrr(`PTS_A_NSTEPS, 32'h2);
        wrr(`PTS_A_COUNT, 32'h2);
        wrr(`PTS_A_CTRL, 32'h200);
        press(1);
        cyc(1);
        ck(32'(ls), 32'h2);
        for (int j = 0; j < 4; j++) begin
            press(0);
            cyc(10);
            ck({16'(ls), vs}, {16'h8, 16'hA00 + 16'(j % 2)});
            ck(32'(cs), 32'h500 + j % 2);
        end
        press(0);
        cyc(1);
        ck(32'(ls), 32'h2);
        wrr(`PTS_A_CTRL, 32'h202);
        press(0);
        tev(1'b0);
        wrr(`PTS_A_CMD, 32'h1);
        tev(1'b1);
        wrr(`PTS_A_CTRL, 32'h201);
        fork
            u_ttl.pulse();
            tev(1'b1);
        join
        u_ttl.set_lvl(1'b1);
        wrr(`PTS_A_CTRL, 32'h000);
        press(0);
        tev(1'b1);
        press(1);
        press(0);
        tev(1'b1);
        ck(32'(ls), 32'h1);
    endtask
    task automatic t_cont();
        press(1);
        press(0);
        press(0);
        tev(1'b1);
        cyc(3);
        ck(32'(ls), 32'h4);
        cyc(8);
        ck(32'(ls), 32'h2);
        press(1);
        cyc(1);
        ck(32'(ls), 32'h1);
    endtask
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (80000) @(posedge core_clk);
        err_total++;
        finish_test();
    end
    initial begin
        a <= 8'h00;
        wd <= 32'h0;
        wr <= 1'b0;
        rd <= 1'b0;
        kt <= 1'b0;
        kl <= 1'b0;
        ko <= 1'b0;
        sb <= 4'h0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        cyc(3);
        t_reset();
        t_out();
        t_shut();
        t_fault();
        t_dio();
        t_lock();
        t_list();
        t_cont();
        finish_test();
    end
endmodule
`default_nettype wire
